// *** design/hdf_pkg.sv ***
// Package: register map, field positions and sizes of the HDLC FIFO block
package hdf_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DEPTH      = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned TX_TAG_W   = 7;
  localparam int unsigned RX_TAG_W   = 4;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFS_TX_CONT    = 8'h04;
  localparam logic [7:0] OFS_TX_TERM    = 8'h08;
  localparam logic [7:0] OFS_RX_PORT    = 8'h0C;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  // ---------------------------------------------------------------
  // Interrupt enable fields and writable mask
  // ---------------------------------------------------------------
  localparam int unsigned IE_RX_AVAIL        = 9;
  localparam int unsigned IE_RX_FLAG_SEEN    = 11;
  localparam int unsigned IE_CARRIER_CHANGE  = 13;
  localparam int unsigned IE_RX_GOOD_FRAME   = 14;
  localparam int unsigned IE_RX_LINE_IDLE    = 15;
  localparam int unsigned IE_RX_ABORT        = 16;
  localparam int unsigned IE_RX_CHECK_ERROR  = 17;
  localparam int unsigned IE_DMA_RX_DONE     = 24;
  localparam int unsigned IE_DMA_RX_EMPTY    = 25;
  localparam int unsigned IE_DMA_RX_OWNER    = 26;
  localparam int unsigned IE_DMA_TX_DONE     = 27;
  localparam int unsigned IE_DMA_TX_EMPTY    = 28;
  localparam int unsigned IE_DMA_TX_OWNER    = 29;
  localparam int unsigned IE_CLK_MISS1       = 30;
  localparam int unsigned IE_CLK_MISS2       = 31;
  localparam logic [31:0] IE_MASK            = 32'hFF03EA00;
  localparam logic [31:0] IE_RESET           = 32'h00000000;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTL_TX_RESET      = 0;
  localparam int unsigned CTL_TX_ABORT      = 1;
  localparam int unsigned CTL_RX_RESET      = 2;
  localparam int unsigned CTL_TX_FOUR_WORD  = 3;
  localparam int unsigned CTL_RX_FOUR_WORD  = 4;
  localparam int unsigned CTL_AUTO_ENABLE   = 5;
  localparam int unsigned CTL_SUPPRESS_CHK  = 6;
  localparam int unsigned CTL_PREAMBLE      = 7;
  localparam int unsigned CTL_W             = 8;
  localparam logic [7:0]  CTL_RESET         = 8'h00;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int unsigned ST_TX_SPACE  = 0;
  localparam int unsigned ST_RX_AVAIL  = 1;
  localparam int unsigned ST_RX_LAST   = 2;
  localparam int unsigned ST_RX_OVR    = 3;
  localparam int unsigned ST_RX_CRC    = 4;
  localparam int unsigned ST_RX_NONOCT = 5;
  localparam int unsigned ST_W         = 6;

  // ---------------------------------------------------------------
  // Tag layouts
  // ---------------------------------------------------------------
  localparam int unsigned TT_BV_LO = 0;
  localparam int unsigned TT_EOF   = 4;
  localparam int unsigned TT_SUPPRESS_CHECK_TAG = 5;
  localparam int unsigned TT_PRE   = 6;
  localparam logic [3:0]  BV_ALL   = 4'hF;
  localparam int unsigned RT_LAST  = 0;
  localparam int unsigned RT_OVR   = 1;
  localparam int unsigned RT_CRC   = 2;
  localparam int unsigned RT_NONOCT = 3;

endpackage

// *** design/hdf_fifo.sv ***
// Module: HDLC transmit and receive FIFOs with interrupt enable register
// Function
// - Receive interrupt enables sit at bits 9, 11, 13-17; 10 and 12 reserved.
// - DMA event interrupt enables sit at bits 24 through 29.
// - Bits 30 and 31 enable one and two missing recovered-clock edge interrupts.
// - Transmit FIFO is eight 32-bit stages shifting toward the transmitter end.
// - Each transmit stage carries byte-valid, end-of-frame, suppress-check, preamble tags.
// - Continue address sets byte-valid tags; terminate address also sets end-of-frame.
// - Suppress-check tag decides whether the frame check sequence is appended.
// - Writing transmit abort or transmit reset clears all transmit tags.
// - DMA sets end-of-frame on the final byte when descriptor last flag set.
// - Long DMA frames keep end-of-frame clear until the descriptor with last flag.
// - Rising byte-valid at the output stage starts a frame with an opening flag.
// - Falling end-of-frame at the output stage closes frame with check and flag.
// - Transmit-space status reads one when FIFO accepts data, per four-word select.
// - Transmit reset, abort or global reset empties FIFO, forces space low, ignores writes.
// - Receive FIFO is eight 32-bit stages, shifting, each with frame-status tags.
// - Tags at the one-word or four-word read location update receive status bits.
// - Receive-available status is one when ready to read, per four-word select.
// - After a receive overrun the overrun frame's data is invalid.
// - In-frame abort or carrier high with auto-enable flushes the current frame only.
// - Receive reset or global reset clears receive FIFO contents.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns

module hdf_fifo (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // DMA transmit write port
  input  wire logic        dma_tx_wr_in,
  input  wire logic [31:0] dma_tx_data_in,
  input  wire logic [3:0]  dma_tx_bytes_in,
  input  wire logic        dma_tx_buf_end_in,
  input  wire logic        dma_tx_desc_last_in,
  // Serial transmitter side
  input  wire logic        tx_pop_in,
  output logic             tx_valid_out,
  output logic      [31:0] tx_data_out,
  output logic      [3:0]  tx_bytes_out,
  output logic             tx_eof_out,
  output logic             tx_preamble_out,
  output logic             tx_frame_open_out,
  output logic             tx_frame_close_out,
  output logic             tx_append_check_out,
  // Serial receiver side
  input  wire logic        rx_wr_in,
  input  wire logic [31:0] rx_data_in,
  input  wire logic        rx_last_in,
  input  wire logic        rx_crc_err_in,
  input  wire logic        rx_nonoct_in,
  input  wire logic        rx_abort_in,
  input  wire logic        carrier_detect_n_in,
  // Status and configuration to the channel
  output logic      [31:0] irq_enable_out,
  output logic             tx_space_status_out,
  output logic             rx_avail_status_out
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int unsigned TOP = hdf_pkg::DEPTH - 1;

  logic [31:0]                 hdlc_irq_enable;
  logic [hdf_pkg::CTL_W-1:0]   hdlc_control_reg;
  logic [hdf_pkg::ST_W-1:0]    status;
  logic [31:0]                 tx_data [0:TOP];
  logic [hdf_pkg::TX_TAG_W-1:0] tx_tag [0:TOP];
  logic [TOP:0]                tx_full;
  logic [31:0]                 rx_data [0:TOP];
  logic [hdf_pkg::RX_TAG_W-1:0] rx_tag [0:TOP];
  logic [TOP:0]                rx_full;
  logic                        rx_dropping;
  logic                        tx_out_bv_prev;
  logic                        tx_out_eof_prev;

  // Four free (or four filled) stages at one end
  function automatic logic hdf_all_clear(input logic [3:0] v);
    hdf_all_clear = (v == 4'h0);
  endfunction

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_ie      = reg_wr_in & (reg_addr_in == hdf_pkg::OFS_IRQ_ENABLE);
  wire wr_cont    = reg_wr_in & (reg_addr_in == hdf_pkg::OFS_TX_CONT);
  wire wr_term    = reg_wr_in & (reg_addr_in == hdf_pkg::OFS_TX_TERM);
  wire wr_ctl     = reg_wr_in & (reg_addr_in == hdf_pkg::OFS_CONTROL);
  wire rd_rx      = reg_rd_in & (reg_addr_in == hdf_pkg::OFS_RX_PORT);
  wire tx_hold    = hdlc_control_reg[hdf_pkg::CTL_TX_RESET]
                  | hdlc_control_reg[hdf_pkg::CTL_TX_ABORT];
  wire rx_hold    = hdlc_control_reg[hdf_pkg::CTL_RX_RESET];
  wire tx_four    = hdlc_control_reg[hdf_pkg::CTL_TX_FOUR_WORD];
  wire rx_four    = hdlc_control_reg[hdf_pkg::CTL_RX_FOUR_WORD];

  // ---------------------------------------------------------------
  // Transmit load selection
  // ---------------------------------------------------------------
  wire       cpu_tx_wr  = wr_cont | wr_term;
  wire       tx_load    = (cpu_tx_wr | dma_tx_wr_in) & ~tx_full[0] & ~tx_hold;
  wire [31:0] tx_in_data = cpu_tx_wr ? reg_wdata_in : dma_tx_data_in;
  wire [3:0] tx_in_bv   = cpu_tx_wr ? hdf_pkg::BV_ALL : dma_tx_bytes_in;
  wire       tx_in_eof  = cpu_tx_wr ? wr_term
                        : (dma_tx_buf_end_in & dma_tx_desc_last_in);
  wire [hdf_pkg::TX_TAG_W-1:0] tx_in_tag = {hdlc_control_reg[hdf_pkg::CTL_PREAMBLE],
                                            hdlc_control_reg[hdf_pkg::CTL_SUPPRESS_CHK],
                                            tx_in_eof, tx_in_bv};

  // ---------------------------------------------------------------
  // Receive flush and load selection
  // ---------------------------------------------------------------
  wire rx_overrun   = rx_wr_in & rx_full[0] & ~rx_dropping & ~rx_last_in & ~rx_hold;
  wire rx_flush     = rx_abort_in | rx_overrun
                    | (carrier_detect_n_in
                       & hdlc_control_reg[hdf_pkg::CTL_AUTO_ENABLE]);
  wire rx_load      = rx_wr_in & ~rx_full[0] & ~rx_hold & ~rx_flush
                    & (~rx_dropping | rx_last_in);
  wire [hdf_pkg::RX_TAG_W-1:0] rx_in_tag = {rx_nonoct_in, rx_crc_err_in,
                                            rx_dropping, rx_last_in};
  wire rx_pop       = rd_rx & rx_full[TOP];

  // ---------------------------------------------------------------
  // Stage movement: word steps one stage toward the output end
  // ---------------------------------------------------------------
  logic [TOP:0] tx_move;
  logic [TOP:0] rx_move;
  logic [TOP:0] rx_keep;
  genvar g;
  generate
    for (g = 0; g < TOP; g = g + 1) begin : g_move
      assign tx_move[g] = tx_full[g] & ~tx_full[g+1];
      assign rx_move[g] = rx_full[g] & ~rx_full[g+1];
    end
    for (g = 1; g <= TOP; g = g + 1) begin : g_keep
      assign rx_keep[g] = (rx_full[g] & rx_tag[g][hdf_pkg::RT_LAST]) | rx_keep[g-1];
    end
  endgenerate
  assign tx_move[TOP] = tx_full[TOP] & tx_pop_in;
  assign rx_move[TOP] = rx_pop;
  assign rx_keep[0]   = rx_full[0] & rx_tag[0][hdf_pkg::RT_LAST];

  // ---------------------------------------------------------------
  // Transmit stages
  // ---------------------------------------------------------------
  generate
    for (g = 0; g <= TOP; g = g + 1) begin : g_tx
      wire fill = (g == 0) ? tx_load : tx_move[(g == 0) ? 0 : g-1];
      wire [31:0] src_d = (g == 0) ? tx_in_data : tx_data[(g == 0) ? 0 : g-1];
      wire [hdf_pkg::TX_TAG_W-1:0] src_t = (g == 0) ? tx_in_tag : tx_tag[(g == 0) ? 0 : g-1];
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          tx_full[g] <= 1'b0;
          tx_tag[g]  <= '0;
          tx_data[g] <= 32'h00000000;
        end else if (tx_hold) begin
          tx_full[g] <= 1'b0;
          tx_tag[g]  <= '0;
        end else if (fill) begin
          tx_full[g] <= 1'b1;
          tx_tag[g]  <= src_t;
          tx_data[g] <= src_d;
        end else if (tx_move[g]) begin
          tx_full[g] <= 1'b0;
          tx_tag[g]  <= '0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Receive stages
  // ---------------------------------------------------------------
  generate
    for (g = 0; g <= TOP; g = g + 1) begin : g_rx
      wire fill = (g == 0) ? rx_load : rx_move[(g == 0) ? 0 : g-1];
      wire [31:0] src_d = (g == 0) ? rx_data_in : rx_data[(g == 0) ? 0 : g-1];
      wire [hdf_pkg::RX_TAG_W-1:0] src_t = (g == 0) ? rx_in_tag : rx_tag[(g == 0) ? 0 : g-1];
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          rx_full[g] <= 1'b0;
          rx_tag[g]  <= '0;
          rx_data[g] <= 32'h00000000;
        end else if (rx_hold) begin
          rx_full[g] <= 1'b0;
          rx_tag[g]  <= '0;
        end else if (rx_flush) begin
          rx_full[g] <= rx_full[g] & rx_keep[g] & ~(g == TOP && rx_pop);
        end else if (fill) begin
          rx_full[g] <= 1'b1;
          rx_tag[g]  <= src_t;
          rx_data[g] <= src_d;
        end else if (rx_move[g]) begin
          rx_full[g] <= 1'b0;
          rx_tag[g]  <= '0;
        end
      end
    end
  endgenerate

  // Overrun drop: rest of the frame is discarded up to its last word
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_dropping <= 1'b0;
    end else if (rx_hold || rx_abort_in) begin
      rx_dropping <= 1'b0;
    end else if (rx_overrun) begin
      rx_dropping <= 1'b1;
    end else if (rx_wr_in && rx_last_in) begin
      rx_dropping <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status computation
  // ---------------------------------------------------------------
  wire [3:0] rx_low_full = rx_full[TOP:TOP-3];
  wire [3:0] rx_region_last;
  wire [3:0] rx_region_ovr;
  wire [3:0] rx_region_crc;
  wire [3:0] rx_region_non;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_region
      wire in_win = rx_full[TOP-g] & (rx_four | (g == 0));
      assign rx_region_last[g] = in_win & rx_tag[TOP-g][hdf_pkg::RT_LAST];
      assign rx_region_ovr[g]  = in_win & rx_tag[TOP-g][hdf_pkg::RT_OVR];
      assign rx_region_crc[g]  = in_win & rx_tag[TOP-g][hdf_pkg::RT_CRC];
      assign rx_region_non[g]  = in_win & rx_tag[TOP-g][hdf_pkg::RT_NONOCT];
    end
  endgenerate

  wire next_tx_space = ~tx_hold & (tx_four ? hdf_all_clear(tx_full[3:0])
                                           : ~tx_full[0]);
  wire next_rx_avail = ~rx_hold & (rx_four ? (hdf_all_clear(~rx_low_full)
                                              | (|rx_region_last))
                                           : rx_full[TOP]);
  wire [hdf_pkg::ST_W-1:0] next_status = {|rx_region_non, |rx_region_crc,
                                          |rx_region_ovr, |rx_region_last,
                                          next_rx_avail, next_tx_space};

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hdlc_irq_enable  <= hdf_pkg::IE_RESET;
      hdlc_control_reg <= hdf_pkg::CTL_RESET;
      status           <= '0;
    end else begin
      if (wr_ie) begin
        hdlc_irq_enable <= reg_wdata_in & hdf_pkg::IE_MASK;
      end
      if (wr_ctl) begin
        hdlc_control_reg <= reg_wdata_in[hdf_pkg::CTL_W-1:0];
      end
      status <= next_status;
    end
  end

  // Read data, valid only in the cycle after the read strobe
  wire [31:0] read_mux =
      (reg_addr_in == hdf_pkg::OFS_IRQ_ENABLE) ? hdlc_irq_enable :
      (reg_addr_in == hdf_pkg::OFS_RX_PORT)    ? (rx_full[TOP] ? rx_data[TOP] : 32'h00000000) :
      (reg_addr_in == hdf_pkg::OFS_CONTROL)    ? {24'h000000, hdlc_control_reg} :
      (reg_addr_in == hdf_pkg::OFS_STATUS)     ? {26'h0000000, status} :
      32'h00000000;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter frame events
  // ---------------------------------------------------------------
  wire out_bv  = tx_full[TOP] & (|tx_tag[TOP][3:0]);
  wire out_eof = tx_full[TOP] & tx_tag[TOP][hdf_pkg::TT_EOF];

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_out_bv_prev      <= 1'b0;
      tx_out_eof_prev     <= 1'b0;
      tx_frame_open_out   <= 1'b0;
      tx_frame_close_out  <= 1'b0;
      tx_append_check_out <= 1'b0;
    end else begin
      tx_out_bv_prev      <= out_bv & ~tx_move[TOP];
      tx_out_eof_prev     <= out_eof;
      tx_frame_open_out   <= out_bv & ~tx_out_bv_prev & ~tx_out_eof_prev;
      tx_frame_close_out  <= out_eof & tx_move[TOP];
      tx_append_check_out <= ~tx_tag[TOP][hdf_pkg::TT_SUPPRESS_CHECK_TAG];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_valid_out        = tx_full[TOP];
  assign tx_data_out         = tx_data[TOP];
  assign tx_bytes_out        = tx_tag[TOP][3:0];
  assign tx_eof_out          = tx_tag[TOP][hdf_pkg::TT_EOF];
  assign tx_preamble_out     = tx_tag[TOP][hdf_pkg::TT_PRE];
  assign irq_enable_out      = hdlc_irq_enable;
  assign tx_space_status_out = status[hdf_pkg::ST_TX_SPACE];
  assign rx_avail_status_out = status[hdf_pkg::ST_RX_AVAIL];

endmodule

// *** test/hdf_fifo_monitor.sv ***
// Checker: port-level assertions for the HDLC FIFO block
`timescale 1ns/1ns
module hdf_fifo_monitor (
  // Clock, reset and inputs
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        tx_pop_in,
  // Outputs
  input wire logic        tx_valid_out,
  input wire logic [31:0] tx_data_out,
  input wire logic        tx_eof_out,
  input wire logic        tx_frame_open_out,
  input wire logic        tx_frame_close_out,
  input wire logic [31:0] irq_enable_out,
  input wire logic        tx_space_status_out,
  input wire logic        rx_avail_status_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] ctl;
  wire        ctl_wr = reg_wr_in && reg_addr_in == hdf_pkg::OFS_CONTROL;
  wire        tx_hold = ctl[0] || ctl[1];
  wire        keep = tx_valid_out && !tx_pop_in && !tx_hold && !ctl_wr;
  // Shadow of the control register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      ctl <= 8'h00;
    else if (ctl_wr)
      ctl <= reg_wdata_in[7:0];
  end
  chk_ie_reserved: assert property ((irq_enable_out & ~hdf_pkg::IE_MASK) == 32'h0)
    else $error("reserved enable bit set");
  chk_ie_write: assert property (reg_wr_in && reg_addr_in == hdf_pkg::OFS_IRQ_ENABLE
    |=> irq_enable_out == ($past(reg_wdata_in) & hdf_pkg::IE_MASK))
    else $error("enable write not taken");
  chk_hold_space: assert property (tx_hold && $past(tx_hold) |-> !tx_space_status_out)
    else $error("space shown during transmit hold");
  chk_hold_empty: assert property (tx_hold && $past(tx_hold) |-> !tx_valid_out)
    else $error("transmit word kept during hold");
  chk_open_cause: assert property (tx_frame_open_out |-> tx_valid_out || $past(tx_valid_out))
    else $error("frame open without a word");
  chk_close_cause: assert property (
    tx_frame_close_out == $past(tx_pop_in && tx_valid_out && tx_eof_out))
    else $error("frame close not tied to last word");
  chk_rx_clear: assert property (
    ctl[2] && $past(ctl[2]) && $past(ctl[2], 2) |-> !rx_avail_status_out)
    else $error("receive data during receive reset");
  chk_tx_stable: assert property (keep |=> tx_valid_out && $stable(tx_data_out))
    else $error("output stage changed without pop");
endmodule

// *** test/hdf_dma_model.sv ***
// Partner: DMA engine model streaming buffer words into the transmit FIFO
`timescale 1ns/1ns
module hdf_dma_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Command
  input  wire logic        start_in,
  input  wire logic        last_in,
  input  wire logic [3:0]  count_in,
  input  wire logic [3:0]  gap_in,
  // Write port
  output logic             wr_out,
  output logic      [31:0] data_out,
  output logic      [3:0]  bytes_out,
  output logic             buf_end_out,
  output logic             desc_last_out
);
  logic [3:0] left;
  logic [3:0] idx;
  logic [3:0] wait_cnt;
  wire        fire = left != 4'h0 && wait_cnt == 4'h0;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {left, idx, wait_cnt, bytes_out} <= 16'h0;
      {wr_out, buf_end_out, desc_last_out} <= 3'h0;
      data_out <= 32'h0;
    end else begin
      wr_out <= fire;
      bytes_out <= fire ? 4'hF : 4'h0;
      data_out <= fire ? {idx, 28'h5A3C0F1} : ~data_out;
      buf_end_out <= fire && left == 4'h1;
      desc_last_out <= fire && last_in;
      if (start_in)
        {left, idx, wait_cnt} <= {count_in, 8'h00};
      else if (fire)
        {left, idx, wait_cnt} <= {left - 4'h1, idx + 4'h1, gap_in + 4'h1};
      else if (wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

// *** test/hdf_fifo_tb_top.sv ***
// Testbench: drives the HDLC FIFO block, scores reads and transmit words
`timescale 1ns/1ns
module hdf_fifo_tb_top;
  logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        tx_pop_in = 1'b0, rx_wr_in = 1'b0, rx_last_in = 1'b0, rx_crc_err_in = 1'b0;
  logic        rx_nonoct_in = 1'b0, rx_abort_in = 1'b0, carrier_detect_n_in = 1'b0;
  logic        dma_go = 1'b0, dma_last = 1'b0, pop_en = 1'b0, rd_d = 1'b0;
  logic [3:0]  dma_n = 4'h0, dma_gap = 4'h0, dma_tx_bytes_in, tx_bytes_out;
  logic [7:0]  reg_addr_in = 8'h00, ctl = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, rx_data_in = 32'h0, seed = 32'h9602, v;
  logic [31:0] dma_tx_data_in, reg_rdata_out, tx_data_out, irq_enable_out;
  logic        dma_tx_wr_in, dma_tx_buf_end_in, dma_tx_desc_last_in, tx_valid_out;
  logic        tx_eof_out, tx_preamble_out, tx_frame_open_out, tx_frame_close_out;
  logic        tx_append_check_out, tx_space_status_out, rx_avail_status_out;
  logic [31:0] rdq[$];
  logic [38:0] txq[$];
  int          mismatches = 0, num_checks = 0;
  hdf_fifo u_hdf_fifo (.*);
  hdf_dma_model u_hdf_dma_model (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .start_in(dma_go),
    .last_in(dma_last), .count_in(dma_n), .gap_in(dma_gap), .wr_out(dma_tx_wr_in),
    .data_out(dma_tx_data_in), .bytes_out(dma_tx_bytes_in), .buf_end_out(dma_tx_buf_end_in),
    .desc_last_out(dma_tx_desc_last_in));
  always #5 ref_clk_in = ~ref_clk_in;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input logic [38:0] g, e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // Whole-word reads only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic st(input logic [31:0] e);
    repeat (8) @(posedge ref_clk_in);
    rd(hdf_pkg::OFS_STATUS, e);
  endtask
  task automatic setc(input logic [7:0] c);
    ctl = c;
    wr(hdf_pkg::OFS_CONTROL, {24'h0, c});
  endtask
  task automatic txw(input logic t, input logic [31:0] d);
    txq.push_back({!ctl[6], ctl[7], 4'hF, t, d});
    wr(t ? hdf_pkg::OFS_TX_TERM : hdf_pkg::OFS_TX_CONT, d);
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && txq.size() != 0; i++)
      @(posedge ref_clk_in);
    repeat (20) @(posedge ref_clk_in);
    cmp(39'(txq.size()), 39'h0);
  endtask
  task automatic dma(input logic [3:0] n, g, input logic l);
    for (int i = 0; i < n; i++)
      txq.push_back({1'b1, ctl[7], 4'hF, l && i == n - 1, 4'(i), 28'h5A3C0F1});
    {dma_n, dma_gap, dma_last, dma_go} <= {n, g, l, 1'b1};
    @(posedge ref_clk_in);
    dma_go <= 1'b0;
    drain();
  endtask
  task automatic rxw(input logic [31:0] d, input logic l, c);
    {rx_data_in, rx_last_in, rx_crc_err_in, rx_wr_in} <= {d, l, c, 1'b1};
    @(posedge ref_clk_in);
    rx_wr_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask
  // Scoreboard: oldest note against each result
  always @(posedge ref_clk_in) rd_d <= reg_rd_in;
  always @(posedge ref_clk_in) tx_pop_in <= pop_en && tx_valid_out && !tx_pop_in;
  always @(negedge ref_clk_in) begin
    if (rd_d)
      cmp(39'(reg_rdata_out), rdq.size() ? 39'(rdq.pop_front()) : 39'hX);
    if (tx_pop_in && tx_valid_out)
      cmp({tx_append_check_out, tx_preamble_out, tx_bytes_out, tx_eof_out, tx_data_out},
        txq.size() ? txq.pop_front() : 39'hX);
  end
  // Watchdog at about sixty times the expected run
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    mismatches++;
    results();
  end
  initial begin
    repeat (12) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rd(hdf_pkg::OFS_CONTROL, 32'h0);
    rd(hdf_pkg::OFS_IRQ_ENABLE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = i ? xs() : 32'hFFFFFFFF;
      wr(hdf_pkg::OFS_IRQ_ENABLE, v);
      rd(hdf_pkg::OFS_IRQ_ENABLE, v & hdf_pkg::IE_MASK);
    end
    rd(8'hFC, 32'h0);
    $display("register map test done");
    pop_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      setc(8'(i << 6));
      txw(1'b0, xs());
      txw(1'b1, xs());
    end
    setc(8'h00);
    drain();
    dma(4'h3, 4'h0, 1'b1);
    dma(4'h2, 4'h3, 1'b0);
    dma(4'h1, 4'h1, 1'b1);
    pop_en <= 1'b0;
    setc(8'h08);
    for (int i = 1; i < 6; i++) begin
      txw(1'b0, xs());
      if (i == 3 || i == 5)
        st({31'h0, i == 3});
    end
    setc(8'h00);
    st(32'h1);
    for (int b = 1; b < 3; b++) begin
      setc(8'(b));
      st(32'h0);
      wr(hdf_pkg::OFS_TX_TERM, xs());
      setc(8'h00);
    end
    txq.delete();
    pop_en <= 1'b1;
    drain();
    $display("transmit path test done");
    v = xs();
    rx_nonoct_in <= 1'b1;
    rxw(v, 1'b1, 1'b1);
    rx_nonoct_in <= 1'b0;
    st(32'h37);
    rd(hdf_pkg::OFS_RX_PORT, v);
    st(32'h1);
    setc(8'h10);
    for (int i = 0; i < 4; i++) begin
      rxw(32'(i) + v, 1'b0, 1'b0);
      st({30'h0, i == 3, 1'b1});
    end
    for (int i = 0; i < 4; i++)
      rd(hdf_pkg::OFS_RX_PORT, 32'(i) + v);
    for (int k = 0; k < 2; k++) begin
      setc(k ? 8'h20 : 8'h00);
      v = xs();
      rxw(v, 1'b1, 1'b0);
      rxw(~v, 1'b0, 1'b0);
      {rx_abort_in, carrier_detect_n_in} <= {!k[0], k[0]};
      @(posedge ref_clk_in);
      {rx_abort_in, carrier_detect_n_in} <= 2'b00;
      st(32'h7);
      rd(hdf_pkg::OFS_RX_PORT, v);
      rd(hdf_pkg::OFS_RX_PORT, 32'h0);
    end
    rxw(xs(), 1'b1, 1'b0);
    setc(8'h04);
    st(32'h1);
    setc(8'h00);
    rd(hdf_pkg::OFS_RX_PORT, 32'h0);
    $display("receive path test done");
    results();
  end
endmodule
bind hdf_fifo hdf_fifo_monitor u_hdf_fifo_monitor (.*);
